// ==== shared/phy_aux_params.svh ====
// Offsets, field positions, reset values and limits of the PHY auxiliary registers
`ifndef PHY_AUX_PARAMS_SVH
`define PHY_AUX_PARAMS_SVH

// Management register offsets
`define ADDR_TX100_AUX_STATUS    5'h11
`define ADDR_RX_ERROR_COUNT      5'h12
`define ADDR_FALSE_CARRIER_COUNT 5'h13
`define ADDR_AUX_CONTROL_STATUS  5'h18

// Auxiliary status field positions
`define STS_LOCKED_BIT       9
`define STS_LINK_BIT         8
`define STS_REMOTE_FAULT_BIT 7
`define STS_FALSE_CARR_BIT   5
`define STS_BAD_ESD_BIT      4
`define STS_RX_ERR_BIT       3
`define STS_TX_ERR_BIT       2
`define STS_LOCK_ERR_BIT     1
`define STS_MLT3_ERR_BIT     0

// Auxiliary control/status field positions
`define CTL_JABBER_DIS_BIT 15
`define CTL_FORCE_LINK_BIT 14
`define CTL_SQUELCH_MSB    7
`define CTL_SQUELCH_LSB    6
`define CTL_EDGE_MSB       5
`define CTL_EDGE_LSB       4
`define CTL_AN_IND_BIT     3
`define CTL_FORCE_IND_BIT  2
`define CTL_SPEED_IND_BIT  1
`define CTL_DUPLEX_IND_BIT 0

// Reset values of writable control fields
`define RST_JABBER_DIS 1'h0
`define RST_FORCE_LINK 1'h0
`define RST_SQUELCH    2'h0
`define RST_EDGE_RATE  2'h3

// Counter widths and saturation points
`define RXERR_WIDTH 16
`define FCAR_WIDTH  8
`define RXERR_MAX   16'h00ff
`define FCAR_MAX    8'hff

`endif

// ==== shared/phy_aux_pkg.sv ====
// Types shared by the PHY auxiliary status and error counter block
package phy_aux_pkg;

   typedef enum logic [1:0] {
      SQUELCH_NORMAL = 2'h0,
      SQUELCH_LOW    = 2'h1,
      SQUELCH_HIGH   = 2'h2,
      SQUELCH_ILLEGAL = 2'h3
   } squelch_mode_t;

   typedef enum logic [1:0] {
      EDGE_1NS = 2'h0,
      EDGE_2NS = 2'h1,
      EDGE_3NS = 2'h2,
      EDGE_4NS = 2'h3
   } edge_rate_t;

   // Live receive-path conditions
   typedef struct packed {
      logic descrambler_locked;
      logic link_100_good;
      logic remote_fault;
   } rx_live_t;

   // One-cycle receive-path events
   typedef struct packed {
      logic false_carrier;
      logic bad_esd;
      logic invalid_code;
      logic tx_error_code;
      logic lock_lost;
      logic mlt3_error;
   } rx_event_t;

   // Writable control fields
   typedef struct packed {
      logic          jabber_disable;
      logic          force_link;
      squelch_mode_t squelch;
      edge_rate_t    edge_rate;
   } aux_ctrl_t;

   // Latched-high status flags
   typedef struct packed {
      logic false_carrier;
      logic bad_esd;
      logic rx_error;
      logic tx_error;
      logic lock_error;
      logic mlt3_error;
   } latched_high_flag_t;

endpackage : phy_aux_pkg

// ==== src/phy_aux_status_error_counters.sv ====
// Auxiliary status, error counters and auxiliary control of one PHY port
`timescale 1ns/1ps
`include "phy_aux_params.svh"

module phy_aux_status_error_counters #(
   parameter int                  RXERR_W   = `RXERR_WIDTH,
   parameter int                  FCAR_W    = `FCAR_WIDTH,
   parameter logic [RXERR_W-1:0]  RXERR_SAT = `RXERR_MAX,
   parameter logic [FCAR_W-1:0]   FCAR_SAT  = `FCAR_MAX
) (
   // Clock and reset
   input  wire logic                        clk_sys,
   input  wire logic                        rst_n,
   // Management register access
   input  wire logic [4:0]                  mgmt_addr,
   input  wire logic                        mgmt_rd,
   input  wire logic                        mgmt_wr,
   input  wire logic [15:0]                 mgmt_wdata,
   output logic      [15:0]                 mgmt_rdata,
   output logic                             mgmt_rvalid,
   // Receive path conditions and events
   input  wire phy_aux_pkg::rx_live_t       rx_live,
   input  wire phy_aux_pkg::rx_event_t      rx_event,
   input  wire logic                        rx_err_packet,
   input  wire logic                        rx_collision,
   // Configuration pins and mode inputs
   input  wire logic                        autoneg_enable_pin,
   input  wire logic                        force_fast_speed_pin,
   input  wire logic                        ctrl_autoneg_bit,
   input  wire logic                        ctrl_speed_bit,
   input  wire logic                        speed_100,
   input  wire logic                        autoneg_busy,
   input  wire logic                        full_duplex,
   // Control outputs to the analog and link logic
   output phy_aux_pkg::aux_ctrl_t           aux_ctrl,
   output logic                             jabber_disable,
   output logic                             force_link,
   output logic                             high_squelch_select,
   output logic                             low_squelch_select,
   output phy_aux_pkg::edge_rate_t          edge_rate
);

   generate
      if (RXERR_W < 1 || RXERR_W > 16) begin : g_bad_rxerr
         $error("Receive error counter width must be 1 to 16");
      end
      if (FCAR_W < 1 || FCAR_W > 8) begin : g_bad_fcar
         $error("False carrier counter width must be 1 to 8");
      end
      // A zero ceiling would freeze the counter at reset
      if (RXERR_SAT == '0 || FCAR_SAT == '0) begin : g_bad_sat
         $error("Counter saturation values must be nonzero");
      end
   endgenerate

   // Register selects
   logic                     rd_status;
   logic                     rd_rxerr;
   logic                     rd_fcar;
   logic                     rd_ctrl;
   logic                     wr_ctrl;

   assign rd_status = mgmt_rd && (mgmt_addr == `ADDR_TX100_AUX_STATUS);
   assign rd_rxerr  = mgmt_rd && (mgmt_addr == `ADDR_RX_ERROR_COUNT);
   assign rd_fcar   = mgmt_rd && (mgmt_addr == `ADDR_FALSE_CARRIER_COUNT);
   assign rd_ctrl   = mgmt_rd && (mgmt_addr == `ADDR_AUX_CONTROL_STATUS);
   assign wr_ctrl   = mgmt_wr && (mgmt_addr == `ADDR_AUX_CONTROL_STATUS);

   // Latched-high flags
   phy_aux_pkg::latched_high_flag_t flags;
   phy_aux_pkg::latched_high_flag_t next_flags;
   phy_aux_pkg::latched_high_flag_t flag_set;

   always_comb begin
      flag_set.false_carrier = rx_event.false_carrier;
      flag_set.bad_esd       = rx_event.bad_esd;
      flag_set.rx_error      = rx_event.invalid_code;
      flag_set.tx_error      = rx_event.tx_error_code;
      flag_set.lock_error    = rx_event.lock_lost;
      flag_set.mlt3_error    = rx_event.mlt3_error;
      // Clear on status read, but a same-cycle event survives
      if (rd_status) begin
         next_flags = flag_set;
      end else begin
         next_flags = flags | flag_set;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flags <= '0;
      end else begin
         flags <= next_flags;
      end
   end

   // Error counters
   logic [RXERR_W-1:0]       rxerr_cnt;
   logic [RXERR_W-1:0]       next_rxerr_cnt;
   logic [FCAR_W-1:0]        fcar_cnt;
   logic [FCAR_W-1:0]        next_fcar_cnt;
   logic                     rxerr_inc;
   logic                     fcar_inc;

   assign rxerr_inc = rx_err_packet && !rx_collision;
   assign fcar_inc  = rx_event.false_carrier;

   always_comb begin
      next_rxerr_cnt = rxerr_cnt;
      if (rd_rxerr) begin
         // Event in the clearing cycle counts as the first of the next period
         next_rxerr_cnt = rxerr_inc ? RXERR_W'(1) : '0;
      end else if (rxerr_inc && rxerr_cnt < RXERR_SAT) begin
         next_rxerr_cnt = rxerr_cnt + RXERR_W'(1);
      end
   end

   always_comb begin
      next_fcar_cnt = fcar_cnt;
      if (rd_fcar) begin
         next_fcar_cnt = fcar_inc ? FCAR_W'(1) : '0;
      end else if (fcar_inc && fcar_cnt < FCAR_SAT) begin
         next_fcar_cnt = fcar_cnt + FCAR_W'(1);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rxerr_cnt <= '0;
         fcar_cnt  <= '0;
      end else begin
         rxerr_cnt <= next_rxerr_cnt;
         fcar_cnt  <= next_fcar_cnt;
      end
   end

   // Writable control fields
   phy_aux_pkg::aux_ctrl_t   ctrl;
   phy_aux_pkg::aux_ctrl_t   next_ctrl;

   always_comb begin
      next_ctrl = ctrl;
      if (wr_ctrl) begin
         next_ctrl.jabber_disable = mgmt_wdata[`CTL_JABBER_DIS_BIT];
         next_ctrl.force_link     = mgmt_wdata[`CTL_FORCE_LINK_BIT];
         // Stored as written; writing 11 is the writer's fault
         next_ctrl.squelch = phy_aux_pkg::squelch_mode_t'(
            mgmt_wdata[`CTL_SQUELCH_MSB:`CTL_SQUELCH_LSB]);
         next_ctrl.edge_rate = phy_aux_pkg::edge_rate_t'(
            mgmt_wdata[`CTL_EDGE_MSB:`CTL_EDGE_LSB]);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl.jabber_disable <= `RST_JABBER_DIS;
         ctrl.force_link     <= `RST_FORCE_LINK;
         ctrl.squelch        <= phy_aux_pkg::squelch_mode_t'(`RST_SQUELCH);
         ctrl.edge_rate      <= phy_aux_pkg::edge_rate_t'(`RST_EDGE_RATE);
      end else begin
         ctrl <= next_ctrl;
      end
   end

   assign aux_ctrl            = ctrl;
   assign jabber_disable      = ctrl.jabber_disable;
   assign force_link          = ctrl.force_link;
   assign high_squelch_select = ctrl.squelch[1];
   assign low_squelch_select  = ctrl.squelch[0];
   assign edge_rate           = ctrl.edge_rate;

   // Read-only indications
   logic                     an_ind;
   logic                     force_ind;
   logic                     speed_ind;
   logic                     duplex_ind;

   assign an_ind    = ctrl_autoneg_bit && autoneg_enable_pin;
   assign force_ind = !((!autoneg_enable_pin && !force_fast_speed_pin) ||
                        (autoneg_enable_pin && !ctrl_autoneg_bit &&
                         !ctrl_speed_bit));
   // Negotiation always runs at 10 Mb/s
   assign speed_ind  = speed_100 && !autoneg_busy;
   assign duplex_ind = full_duplex;

   // Read data assembly
   logic [15:0]              status_word;
   logic [15:0]              rxerr_word;
   logic [15:0]              fcar_word;
   logic [15:0]              ctrl_word;

   always_comb begin
      status_word = 16'h0000;
      status_word[`STS_LOCKED_BIT]       = rx_live.descrambler_locked;
      status_word[`STS_LINK_BIT]         = rx_live.link_100_good;
      status_word[`STS_REMOTE_FAULT_BIT] = rx_live.remote_fault;
      status_word[`STS_FALSE_CARR_BIT]   = flags.false_carrier;
      status_word[`STS_BAD_ESD_BIT]      = flags.bad_esd;
      status_word[`STS_RX_ERR_BIT]       = flags.rx_error;
      status_word[`STS_TX_ERR_BIT]       = flags.tx_error;
      status_word[`STS_LOCK_ERR_BIT]     = flags.lock_error;
      status_word[`STS_MLT3_ERR_BIT]     = flags.mlt3_error;
   end

   always_comb begin
      rxerr_word = 16'h0000;
      rxerr_word[RXERR_W-1:0] = rxerr_cnt;
      fcar_word = 16'h0000;
      fcar_word[FCAR_W-1:0] = fcar_cnt;
   end

   always_comb begin
      ctrl_word = 16'h0000;
      ctrl_word[`CTL_JABBER_DIS_BIT] = ctrl.jabber_disable;
      ctrl_word[`CTL_FORCE_LINK_BIT] = ctrl.force_link;
      ctrl_word[`CTL_SQUELCH_MSB:`CTL_SQUELCH_LSB] = ctrl.squelch;
      ctrl_word[`CTL_EDGE_MSB:`CTL_EDGE_LSB] = ctrl.edge_rate;
      ctrl_word[`CTL_AN_IND_BIT]     = an_ind;
      ctrl_word[`CTL_FORCE_IND_BIT]  = force_ind;
      ctrl_word[`CTL_SPEED_IND_BIT]  = speed_ind;
      ctrl_word[`CTL_DUPLEX_IND_BIT] = duplex_ind;
   end

   // Read data register
   logic [15:0]              next_rdata;
   logic                     next_rvalid;

   always_comb begin
      next_rdata  = mgmt_rdata;
      next_rvalid = 1'b0;
      if (mgmt_rd) begin
         next_rvalid = 1'b1;
         // Captured before the clear takes effect
         unique case (mgmt_addr)
            `ADDR_TX100_AUX_STATUS:    next_rdata = status_word;
            `ADDR_RX_ERROR_COUNT:      next_rdata = rxerr_word;
            `ADDR_FALSE_CARRIER_COUNT: next_rdata = fcar_word;
            `ADDR_AUX_CONTROL_STATUS:  next_rdata = ctrl_word;
            default:                   next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mgmt_rdata  <= 16'h0000;
         mgmt_rvalid <= 1'b0;
      end else begin
         mgmt_rdata  <= next_rdata;
         mgmt_rvalid <= next_rvalid;
      end
   end

endmodule : phy_aux_status_error_counters

// ==== testbench/phy_aux_status_error_counters_assertions.sv ====
// Checker for the PHY auxiliary status, counter and control block
`timescale 1ns/1ps
module phy_aux_checker (
   // Clock and reset
   input wire logic                  clk_sys,
   input wire logic                  rst_n,
   // Management port
   input wire logic [4:0]            mgmt_addr,
   input wire logic                  mgmt_rd,
   input wire logic                  mgmt_wr,
   input wire logic [15:0]           mgmt_wdata,
   input wire logic [15:0]           mgmt_rdata,
   input wire logic                  mgmt_rvalid,
   // Live levels and pins
   input wire phy_aux_pkg::rx_live_t rx_live,
   input wire phy_aux_pkg::rx_event_t rx_event,
   input wire logic                  autoneg_enable_pin,
   input wire logic                  force_fast_speed_pin,
   input wire logic                  ctrl_autoneg_bit,
   input wire logic                  ctrl_speed_bit,
   input wire logic                  speed_100,
   input wire logic                  autoneg_busy,
   input wire logic                  full_duplex,
   // Control outputs
   input wire logic                  jabber_disable,
   input wire logic                  force_link,
   input wire logic                  high_squelch_select,
   input wire logic                  low_squelch_select,
   input wire phy_aux_pkg::edge_rate_t edge_rate
);
   logic rd_sts;
   logic rd_fc;
   logic rd_ctl;
   logic wr_ctl;
   logic exp_an;
   logic exp_frc;
   logic exp_spd;
   assign rd_sts = mgmt_rd && mgmt_addr == 5'h11;
   assign rd_fc = mgmt_rd && mgmt_addr == 5'h13;
   assign rd_ctl = mgmt_rd && mgmt_addr == 5'h18;
   assign wr_ctl = mgmt_wr && mgmt_addr == 5'h18;
   assign exp_an = ctrl_autoneg_bit && autoneg_enable_pin;
   assign exp_frc = !(!autoneg_enable_pin && !force_fast_speed_pin) &&
                    !(autoneg_enable_pin && !ctrl_autoneg_bit && !ctrl_speed_bit);
   assign exp_spd = speed_100 && !autoneg_busy;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   property p_rvalid; mgmt_rvalid == $past(mgmt_rd); endproperty
   a_rvalid: assert property (p_rvalid) else $error("read strobe answer wrong");
   property p_live; rd_sts |=> mgmt_rdata[9:7] == $past(rx_live); endproperty
   a_live: assert property (p_live) else $error("live status bits wrong");
   property p_sts_rsv; rd_sts |=> {mgmt_rdata[15:10], mgmt_rdata[6]} == 7'h00; endproperty
   a_sts_rsv: assert property (p_sts_rsv) else $error("status spare bits set");
   property p_fc_hi; rd_fc |=> mgmt_rdata[15:8] == 8'h00; endproperty
   a_fc_hi: assert property (p_fc_hi) else $error("false carrier upper byte set");
   property p_jab; wr_ctl |=> jabber_disable == $past(mgmt_wdata[15]); endproperty
   a_jab: assert property (p_jab) else $error("jabber disable wrong");
   property p_flink; wr_ctl |=> force_link == $past(mgmt_wdata[14]); endproperty
   a_flink: assert property (p_flink) else $error("force link wrong");
   property p_sq;
      wr_ctl |=> {high_squelch_select, low_squelch_select} == $past(mgmt_wdata[7:6]);
   endproperty
   a_sq: assert property (p_sq) else $error("squelch selects wrong");
   property p_edge; wr_ctl |=> edge_rate == $past(mgmt_wdata[5:4]); endproperty
   a_edge: assert property (p_edge) else $error("edge rate wrong");
   property p_an; rd_ctl |=> mgmt_rdata[3] == $past(exp_an); endproperty
   a_an: assert property (p_an) else $error("negotiation indication wrong");
   property p_frc; rd_ctl |=> mgmt_rdata[2] == $past(exp_frc); endproperty
   a_frc: assert property (p_frc) else $error("forced speed indication wrong");
   property p_spd; rd_ctl |=> mgmt_rdata[1] == $past(exp_spd); endproperty
   a_spd: assert property (p_spd) else $error("speed indication wrong");
   property p_fdx; rd_ctl |=> mgmt_rdata[0] == $past(full_duplex); endproperty
   a_fdx: assert property (p_fdx) else $error("duplex indication wrong");
   property p_keep;
      (rd_sts && rx_event != 6'h00) ##1 !mgmt_rd ##1 rd_sts |=>
         (mgmt_rdata[5:0] & $past(rx_event, 3)) == $past(rx_event, 3);
   endproperty
   a_keep: assert property (p_keep) else $error("event in clearing read lost");
   c_flag: cover property (rd_sts ##1 mgmt_rdata[5:0] != 6'h00);
   c_wr: cover property (wr_ctl);
   c_sat: cover property (rd_fc ##1 mgmt_rdata[7:0] == 8'hff);
endmodule : phy_aux_checker

bind phy_aux_status_error_counters phy_aux_checker u_chk (.clk_sys, .rst_n, .mgmt_addr,
   .mgmt_rd, .mgmt_wr, .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid, .rx_live, .rx_event,
   .autoneg_enable_pin, .force_fast_speed_pin, .ctrl_autoneg_bit, .ctrl_speed_bit,
   .speed_100, .autoneg_busy, .full_duplex, .jabber_disable, .force_link,
   .high_squelch_select, .low_squelch_select, .edge_rate);

// ==== testbench/tb_phy_aux_status_error_counters.sv ====
// Self-checking bench for the PHY auxiliary status, counter and control block
`timescale 1ns/1ps
module tb_phy_aux_status_error_counters;
   logic                    clk_sys = 1'b0;
   logic                    rst_n = 1'b0;
   logic [4:0]              mgmt_addr = 5'h00;
   logic                    mgmt_rd = 1'b0;
   logic                    mgmt_wr = 1'b0;
   logic [15:0]             mgmt_wdata = 16'h0000;
   logic [15:0]             mgmt_rdata;
   logic                    mgmt_rvalid;
   phy_aux_pkg::rx_live_t   rx_live = '0;
   phy_aux_pkg::rx_event_t  rx_event = '0;
   logic                    rx_err_packet = 1'b0;
   logic                    rx_collision = 1'b0;
   logic [6:0]              pins = 7'h00; // autoneg_enable_pin force_fast_speed_pin b12 b13 spd busy fdx
   phy_aux_pkg::aux_ctrl_t  aux_ctrl;
   logic                    jabber_disable;
   logic                    force_link;
   logic                    high_squelch_select;
   logic                    low_squelch_select;
   phy_aux_pkg::edge_rate_t edge_rate;
   int                      error_cnt = 0;
   int                      cmp_count = 0;
   int                      cyc = 0;
   logic [15:0]             e;

   phy_aux_status_error_counters dut (.clk_sys, .rst_n, .mgmt_addr, .mgmt_rd, .mgmt_wr,
      .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid, .rx_live, .rx_event, .rx_err_packet,
      .rx_collision, .autoneg_enable_pin(pins[6]), .force_fast_speed_pin(pins[5]),
      .ctrl_autoneg_bit(pins[4]), .ctrl_speed_bit(pins[3]), .speed_100(pins[2]),
      .autoneg_busy(pins[1]), .full_duplex(pins[0]), .aux_ctrl, .jabber_disable,
      .force_link, .high_squelch_select, .low_squelch_select, .edge_rate);

   always #12.5 clk_sys = ~clk_sys;

   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results

   always @(posedge clk_sys) begin
      cyc++;
      // Tests need about 1600 cycles
      if (cyc == 4000) begin
         error_cnt++;
         $display("timeout after %0d cycles", cyc);
         results();
      end
   end

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Read with optional event pulse in the same cycle
   task automatic rd(input logic [4:0] a, input logic [15:0] exp, input logic [5:0] ev = 6'h00);
      @(negedge clk_sys);
      mgmt_addr = a;
      mgmt_rd = 1'b1;
      rx_event = ev;
      @(negedge clk_sys);
      mgmt_rd = 1'b0;
      rx_event = '0;
      chk("rvalid", 16'h0001, {15'h0000, mgmt_rvalid});
      chk($sformatf("reg %h", a), exp, mgmt_rdata);
   endtask : rd

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(negedge clk_sys);
      mgmt_addr = a;
      mgmt_wr = 1'b1;
      mgmt_wdata = d;
      @(negedge clk_sys);
      mgmt_wr = 1'b0;
   endtask : wr

   task automatic burst(input int n, input logic fc);
      repeat (n) begin
         @(negedge clk_sys);
         if (fc) rx_event.false_carrier = 1'b1;
         else rx_err_packet = 1'b1;
         @(negedge clk_sys);
         rx_event = '0;
         rx_err_packet = 1'b0;
      end
   endtask : burst

   function automatic logic [15:0] outs();
      return {10'h000, jabber_disable, force_link, high_squelch_select,
              low_squelch_select, edge_rate};
   endfunction : outs

   initial begin
      repeat (12) @(posedge clk_sys);
      @(negedge clk_sys);
      rst_n = 1'b1;
      rd(5'h18, 16'h0030);
      rd(5'h11, 16'h0000);
      rd(5'h12, 16'h0000);
      rd(5'h1f, 16'h0000);
      rx_live = 3'h5;
      rd(5'h11, 16'h0280);
      rx_live = 3'h2;
      rd(5'h11, 16'h0100);
      rx_live = '0;
      $display("test reset and live done");
      for (int i = 0; i < 6; i++) begin
         rd(5'h11, 16'h0000, 6'(1 << i));
         rd(5'h11, 16'(1 << i));
         rd(5'h11, 16'h0000);
      end
      rd(5'h13, 16'h0001);
      rd(5'h13, 16'h0000);
      $display("test flags done");
      rx_collision = 1'b1;
      burst(2, 1'b0);
      rx_collision = 1'b0;
      burst(3, 1'b0);
      rd(5'h12, 16'h0003);
      rd(5'h12, 16'h0000);
      burst(300, 1'b0);
      rd(5'h12, 16'h00ff);
      burst(300, 1'b1);
      rd(5'h13, 16'h00ff);
      rd(5'h13, 16'h0000, 6'h20);
      rd(5'h13, 16'h0001);
      rd(5'h11, 16'h0020);
      $display("test counters done");
      for (int i = 0; i < 12; i++) begin
         e = {i[0], i[1], 6'h00, 2'(i % 3), 2'(i / 3), 4'h0};
         wr(5'h18, e | 16'h3f0f);
         chk("ctrl outputs", {10'h000, e[15:14], e[7:4]}, outs());
         chk("aux_ctrl", {10'h000, e[15:14], e[7:4]}, {10'h000, aux_ctrl});
         rd(5'h18, e);
      end
      wr(5'h11, 16'hffff);
      rd(5'h11, 16'h0000);
      wr(5'h12, 16'hffff);
      rd(5'h12, 16'h0000);
      @(negedge clk_sys);
      rst_n = 1'b0;
      @(negedge clk_sys);
      chk("ctrl reset", 16'h0003, outs());
      rst_n = 1'b1;
      rd(5'h18, 16'h0030);
      $display("test control done");
      for (int i = 0; i < 128; i++) begin
         pins = 7'(i);
         e = 16'h0030 | {12'h000, pins[4] & pins[6],
              !((!pins[6] & !pins[5]) | (pins[6] & !pins[4] & !pins[3])),
              pins[2] & !pins[1], pins[0]};
         rd(5'h18, e);
      end
      $display("test indications done");
      results();
   end
endmodule : tb_phy_aux_status_error_counters
